/* File: kscfg_regs.sv */
`timescale 1ns/1ps
`include "kscfg_map.svh"
// How it works
// - PWM enabled keeps scanning, ignores sleep bit
// - sleep bit zero shuts down, writable
// - sleep bit reads back current state
// - mode zero clears interrupt on empty queue
// - mode one clears interrupt on queue read
// - lowest bit set disables bus timeout
// - debounce period nine plus field milliseconds
// - ports field zero gives no outputs
// - fields one to five convert columns downward
// - top two bits set convert columns seven-two
// - time field N fires every N debounce periods
// - level field k fires at 2k+2 events
// - either nonzero field may raise interrupt
// - port bit zero drives pin when general
module kscfg_regs import kscfg_pkg::*; #(
   parameter int MS_CYCLES = `KS_MS_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic linkClk,
   input wire logic linkWr,
   input wire logic linkRd,
   input wire logic [7:0] linkAddr,
   input wire logic [7:0] linkWrData,
   output logic [7:0] linkRdData,
   output logic linkBusy,
   input wire logic [4:0] fifoCount,
   input wire logic ccPwmEn,
   input wire logic autoSleepReq,
   input wire logic keyPressEvt,
   input wire logic portIntkCtl,
   output logic scanActive,
   output logic releaseEnable,
   output logic wakeEnable,
   output logic timeoutEnable,
   output logic debounceTick,
   output logic [7:0] columnGpoEn,
   output logic keyIrqOut,
   output logic keyIrqOe
);

   // ---------------- link domain ----------------
   kscfg_req_t hold;
   logic reqTgl;
   logic ackS1, ackS2, ackS3;
   logic [7:0] resp;
   logic ackTgl;
   wire logic linkStart = !linkBusy && (linkWr || linkRd);
   wire logic ackSeen = ackS2 ^ ackS3;

   // capture the access and hold it until the core answers
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         hold <= '0;
         reqTgl <= 1'b0;
         linkBusy <= 1'b0;
      end else if (linkStart) begin
         hold <= '{wr: linkWr, addr: linkAddr, data: linkWrData};
         reqTgl <= ~reqTgl;
         linkBusy <= 1'b1;
      end else if (ackSeen) begin
         linkBusy <= 1'b0;
      end
   end

   // answer toggle back from the core, data taken when it lands
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         ackS1 <= 1'b0;
         ackS2 <= 1'b0;
         ackS3 <= 1'b0;
         linkRdData <= 8'h00;
      end else begin
         ackS1 <= ackTgl;
         ackS2 <= ackS1;
         ackS3 <= ackS2;
         if (ackSeen)
            linkRdData <= resp;
      end
   end

   // ---------------- core domain ----------------
   logic reqS1, reqS2, reqS3;
   kscfg_cfg_t cfg;
   logic [7:0] dbReg;
   logic [7:0] irqReg;
   logic irqPending;
   wire logic reqSeen = reqS2 ^ reqS3;
   wire logic wrCfg = reqSeen && hold.wr && hold.addr == `KS_OFF_GLOBAL_CFG;
   wire logic wrDb = reqSeen && hold.wr && hold.addr == `KS_OFF_DEBOUNCE;
   wire logic wrIrq = reqSeen && hold.wr && hold.addr == `KS_OFF_IRQ_POLICY;
   wire logic fifoReadEvt = reqSeen && !hold.wr &&
                            hold.addr == `KS_OFF_KEY_FIFO;

   // request synchroniser, third stage only for edge detect
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reqS1 <= 1'b0;
         reqS2 <= 1'b0;
         reqS3 <= 1'b0;
      end else begin
         reqS1 <= reqTgl;
         reqS2 <= reqS1;
         reqS3 <= reqS2;
      end
   end

   wire logic next_scanActive = ccPwmEn || cfg.sleep;
   wire logic wakeHit = keyPressEvt && cfg.wakeEn;
   // sleep bit sources, pwm freezes it
   wire logic next_sleep = ccPwmEn ? cfg.sleep :
                           wrCfg ? hold.data[`KS_CFG_SLEEP] :
                           wakeHit ? 1'b1 :
                           autoSleepReq ? 1'b0 : cfg.sleep;

   // global configuration register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= '{`KS_RST_SLEEP, `KS_RST_CLR_MODE, `KS_RST_REL_EN,
                  `KS_RST_WAKE_EN, `KS_RST_TO_DIS};
      end else begin
         cfg.sleep <= next_sleep;
         if (wrCfg) begin
            cfg.clrMode <= hold.data[`KS_CFG_CLR_MODE];
            cfg.relEn <= hold.data[`KS_CFG_REL_EN];
            cfg.wakeEn <= hold.data[`KS_CFG_WAKE_EN];
            cfg.toDis <= hold.data[`KS_CFG_TO_DIS];
         end
      end
   end

   // debounce and interrupt policy registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dbReg <= `KS_RST_DEBOUNCE;
         irqReg <= `KS_RST_IRQ_POLICY;
      end else begin
         if (wrDb)
            dbReg <= hold.data;
         if (wrIrq)
            irqReg <= hold.data;
      end
   end

   wire logic [7:0] cfgRead = {next_scanActive, 1'b0, cfg.clrMode, 1'b0,
                               cfg.relEn, 1'b0, cfg.wakeEn, cfg.toDis};
   wire logic [7:0] readMux =
      hold.addr == `KS_OFF_GLOBAL_CFG ? cfgRead :
      hold.addr == `KS_OFF_DEBOUNCE ? dbReg :
      hold.addr == `KS_OFF_IRQ_POLICY ? irqReg : 8'h00;

   // answer: latch read data and toggle back on the same edge
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         resp <= 8'h00;
         ackTgl <= 1'b0;
      end else if (reqSeen) begin
         resp <= readMux;
         ackTgl <= ~ackTgl;
      end
   end

   // one millisecond prescaler and debounce period
   logic [15:0] msCnt;
   logic [5:0] dbCnt;
   wire logic [4:0] dbField = dbReg[`KS_DB_TIME_MSB:0];
   wire logic [5:0] dbLast = 6'({1'b0, `KS_DB_BASE_MS} + {1'b0, dbField}
                                - 6'h01);
   wire logic msTick = msCnt == 16'(MS_CYCLES - 1);
   wire logic dbHit = msTick && dbCnt >= dbLast;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         msCnt <= 16'h0000;
         dbCnt <= 6'h00;
         debounceTick <= 1'b0;
      end else begin
         msCnt <= msTick ? 16'h0000 : msCnt + 16'h0001;
         if (msTick)
            dbCnt <= dbHit ? 6'h00 : dbCnt + 6'h01;
         debounceTick <= dbHit;
      end
   end

   // count debounce periods up to N
   logic [4:0] periodCnt;
   wire logic [4:0] timeField = irqReg[`KS_IRQ_TIME_MSB:0];
   wire logic [2:0] levelField = irqReg[7:`KS_IRQ_LEVEL_LSB];
   wire logic timeHit = dbHit && timeField != 5'h00 &&
                        periodCnt >= timeField - 5'h01;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         periodCnt <= 5'h00;
      else if (timeField == 5'h00)
         periodCnt <= 5'h00;
      else if (dbHit)
         periodCnt <= timeHit ? 5'h00 : periodCnt + 5'h01;
   end

   wire logic [4:0] levelMark = 5'({levelField, 1'b0}) + `KS_IRQ_LEVEL_BASE;
   wire logic levelHit = levelField != 3'h0 && fifoCount >= levelMark;
   // either trigger sets the pending interrupt
   wire logic setEvt = levelHit || (timeHit && fifoCount != 5'h00);
   wire logic clrEvt = cfg.clrMode ? fifoReadEvt : fifoCount == 5'h00;
   // all-zero policy means no key interrupts
   wire logic irqOff = irqReg == 8'h00;
   wire logic next_irqPending = !irqOff && (setEvt || (irqPending && !clrEvt));

   // pending interrupt, set wins over clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         irqPending <= 1'b0;
      else
         irqPending <= next_irqPending;
   end

   // top bits both set give six columns
   wire logic [2:0] portsField = dbReg[7:`KS_DB_PORTS_LSB];
   wire logic [2:0] gpoCols = portsField[2:1] == 2'b11 ?
                              `KS_GPO_MAX_COLS : portsField;
   logic [7:0] next_columnGpoEn;

   // columns converted from the top down
   for (genvar c = 0; c < 8; c++) begin : g_col
      if (c < `KS_GPO_LOW_COL) begin : g_never
         assign next_columnGpoEn[c] = 1'b0;
      end else begin : g_maybe
         assign next_columnGpoEn[c] = 4'(gpoCols) >= 4'(8 - c);
      end
   end

   wire logic next_keyIrqOe = irqOff ? !portIntkCtl : next_irqPending;

   // registered outputs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scanActive <= 1'b0;
         releaseEnable <= `KS_RST_REL_EN;
         wakeEnable <= `KS_RST_WAKE_EN;
         timeoutEnable <= !`KS_RST_TO_DIS;
         columnGpoEn <= 8'h00;
         keyIrqOut <= 1'b0;
         keyIrqOe <= 1'b0;
      end else begin
         scanActive <= next_scanActive;
         releaseEnable <= cfg.relEn;
         wakeEnable <= cfg.wakeEn;
         timeoutEnable <= !cfg.toDis;
         columnGpoEn <= next_columnGpoEn;
         keyIrqOut <= 1'b0;
         keyIrqOe <= next_keyIrqOe;
      end
   end

   // checks on the core domain
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_pwm_keeps_scan: assert property (
      ccPwmEn ##1 ccPwmEn |=> scanActive && $stable(cfg.sleep))
      else $error("scan stopped while pwm enabled");
   a_sleep_write: assert property (
      wrCfg && !ccPwmEn |=> ##1 scanActive == $past(hold.data[7], 2))
      else $error("sleep write not applied");
   a_sleep_readback: assert property (
      reqSeen && !hold.wr && hold.addr == `KS_OFF_GLOBAL_CFG
      |=> resp[7] == scanActive)
      else $error("sleep readback wrong");
   a_clear_on_empty: assert property (
      !cfg.clrMode && fifoCount == 5'h00 && !setEvt |=> !irqPending)
      else $error("interrupt held with empty queue");
   a_clear_on_read: assert property (
      cfg.clrMode && fifoReadEvt && !setEvt |=> !irqPending ##1 !keyIrqOe
      || irqOff)
      else $error("interrupt not cleared by read");
   a_release_gate: assert property (
      wrCfg |=> ##1 releaseEnable == $past(hold.data[3], 2))
      else $error("release enable not applied");
   a_wake_gate: assert property (
      keyPressEvt && !cfg.wakeEn && !wrCfg && !autoSleepReq && !ccPwmEn
      |=> $stable(cfg.sleep))
      else $error("woke with autowake disabled");
   a_timeout_bit: assert property (
      wrCfg |=> ##1 timeoutEnable == !$past(hold.data[0], 2))
      else $error("timeout enable wrong");
   a_db_period: assert property (
      dbHit |-> dbCnt == 6'({1'b0, dbField} + 6'h08))
      else $error("debounce period wrong");
   a_cols_none: assert property (
      portsField == 3'h0 |=> columnGpoEn == 8'h00)
      else $error("column output with field zero");
   a_cols_step: assert property (
      portsField == 3'h3 |=> columnGpoEn == 8'hE0)
      else $error("column outputs wrong for three");
   a_cols_top: assert property (
      portsField[2:1] == 2'b11 |=> columnGpoEn == 8'hFC)
      else $error("column outputs wrong for top bits");
   a_period_set: assert property (
      timeHit && fifoCount != 5'h00 && !irqOff |=> irqPending ##1 keyIrqOe)
      else $error("periodic trigger missed");
   a_level_set: assert property (
      levelHit |-> fifoCount >= 5'h04 ##1 irqPending)
      else $error("queue level trigger missed");
   a_either_trig: assert property (
      setEvt && !irqOff |=> irqPending)
      else $error("trigger did not raise interrupt");
   a_off_quiet: assert property (
      irqOff |=> !irqPending)
      else $error("interrupt while policy zero");
   a_gpo_pin: assert property (
      irqOff |=> keyIrqOe == !$past(portIntkCtl) && !keyIrqOut)
      else $error("general output pin wrong");

   c_cfg_write: cover property (wrCfg ##[1:20] reqSeen);
   c_read_clear: cover property (cfg.clrMode && irqPending ##1 fifoReadEvt);
   c_level: cover property (levelHit ##1 irqPending);
   c_period: cover property (timeHit && !irqOff);

endmodule

/* File: kscfg_map.svh */
`ifndef KSCFG_MAP_SVH
`define KSCFG_MAP_SVH

// register offsets
`define KS_OFF_KEY_FIFO 8'h00
`define KS_OFF_GLOBAL_CFG 8'h01
`define KS_OFF_DEBOUNCE 8'h02
`define KS_OFF_IRQ_POLICY 8'h03

// global configuration field positions
`define KS_CFG_SLEEP 7
`define KS_CFG_CLR_MODE 5
`define KS_CFG_REL_EN 3
`define KS_CFG_WAKE_EN 1
`define KS_CFG_TO_DIS 0

// reset values
`define KS_RST_SLEEP 1'b0
`define KS_RST_CLR_MODE 1'b0
`define KS_RST_REL_EN 1'b1
`define KS_RST_WAKE_EN 1'b1
`define KS_RST_TO_DIS 1'b0
`define KS_RST_DEBOUNCE 8'hFF
`define KS_RST_IRQ_POLICY 8'h00

// debounce register layout
`define KS_DB_TIME_MSB 4
`define KS_DB_PORTS_LSB 5
`define KS_DB_BASE_MS 5'h09
`define KS_GPO_LOW_COL 2
`define KS_GPO_MAX_COLS 3'h6

// key interrupt register layout
`define KS_IRQ_TIME_MSB 4
`define KS_IRQ_LEVEL_LSB 5
`define KS_IRQ_LEVEL_BASE 5'h02

// timing: one millisecond at the core clock
`define KS_MS_NS 1000000
`define KS_MCLK_NS 25
`define KS_MS_CYCLES (`KS_MS_NS / `KS_MCLK_NS)

`endif

/* File: kscfg_pkg.sv */
package kscfg_pkg;

   // one register access carried from the link side
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } kscfg_req_t;

   // global configuration fields kept by the block
   typedef struct packed {
      logic sleep;
      logic clrMode;
      logic relEn;
      logic wakeEn;
      logic toDis;
   } kscfg_cfg_t;

endpackage

/* File: kscfg_host_model.sv */
`timescale 1ns/1ps
module kscfg_host_model import kscfg_pkg::*; (
   input wire logic linkClk,
   input wire logic linkBusy,
   input wire logic [7:0] linkRdData,
   output logic linkWr,
   output logic linkRd,
   output logic [7:0] linkAddr,
   output logic [7:0] linkWrData
);
   kscfg_req_t req;
   logic rdReq;
   logic [7:0] rdVal;

   // request struct onto the link pins
   assign linkWr = req.wr;
   assign linkRd = rdReq;
   assign linkAddr = req.addr;
   assign linkWrData = req.data;

   // idle link at time zero
   initial begin
      req = '0;
      rdReq = 1'b0;
      rdVal = 8'h00;
   end

   // one access: present, hold over the taking edge, await the answer
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [7:0] d, input int gap);
      int n;
      n = 0;
      repeat (gap) @(posedge linkClk);
      #1;
      req = '{wr: w, addr: a, data: d};
      rdReq = !w;
      @(posedge linkClk);
      #1;
      // released address and data show the inverse, never a stale copy
      req = '{wr: 1'b0, addr: ~a, data: ~d};
      rdReq = 1'b0;
      do begin
         @(posedge linkClk);
         #1;
         n++;
      end while (linkBusy !== 1'b0 && n < 300);
      rdVal = linkRdData;
   endtask
endmodule

/* File: kscfg_regs_tb_top.sv */
`timescale 1ns/1ps
module kscfg_regs_tb_top;
   logic mclk, rst_n, linkClk, linkWr, linkRd, linkBusy;
   logic [7:0] linkAddr, linkWrData, linkRdData, columnGpoEn, v;
   logic [4:0] fifoCount;
   logic ccPwmEn, autoSleepReq, keyPressEvt, portIntkCtl;
   logic scanActive, releaseEnable, wakeEnable, timeoutEnable;
   logic debounceTick, keyIrqOut, keyIrqOe;
   int err_count, check_count, n, t;
   localparam int MSC = 20;
   localparam logic [7:0] COLS [8] = '{8'h00, 8'h80, 8'hC0, 8'hE0,
      8'hF0, 8'hF8, 8'hFC, 8'hFC};

   kscfg_regs #(.MS_CYCLES(MSC)) i_dut (
      .mclk(mclk), .rst_n(rst_n), .linkClk(linkClk), .linkWr(linkWr),
      .linkRd(linkRd), .linkAddr(linkAddr), .linkWrData(linkWrData),
      .linkRdData(linkRdData), .linkBusy(linkBusy),
      .fifoCount(fifoCount), .ccPwmEn(ccPwmEn),
      .autoSleepReq(autoSleepReq), .keyPressEvt(keyPressEvt),
      .portIntkCtl(portIntkCtl), .scanActive(scanActive),
      .releaseEnable(releaseEnable), .wakeEnable(wakeEnable),
      .timeoutEnable(timeoutEnable), .debounceTick(debounceTick),
      .columnGpoEn(columnGpoEn), .keyIrqOut(keyIrqOut),
      .keyIrqOe(keyIrqOe));
   kscfg_host_model i_host (
      .linkClk(linkClk), .linkBusy(linkBusy), .linkRdData(linkRdData),
      .linkWr(linkWr), .linkRd(linkRd), .linkAddr(linkAddr),
      .linkWrData(linkWrData));

   // core clock and link clock, unrelated in phase
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      linkClk = 1'b0;
      #1.7;
      forever #3 linkClk = ~linkClk;
   end

   // compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
      #2;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host.xfer(1'b1, a, d, 2);
      cyc(2);
   endtask
   task automatic rd(input logic [7:0] a);
      i_host.xfer(1'b0, a, 8'h00, 0);
      v = i_host.rdVal;
      cyc(1);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      check({8'h00, v}, {8'h00, e});
   endtask
   // one core pulse: keypress or autosleep
   task automatic pulse(input bit key);
      keyPressEvt = key;
      autoSleepReq = !key;
      cyc(1);
      keyPressEvt = 1'b0;
      autoSleepReq = 1'b0;
      cyc(2);
   endtask
   function automatic logic [15:0] st();
      return {12'h000, scanActive, releaseEnable, wakeEnable, timeoutEnable};
   endfunction
   function automatic logic [15:0] irq();
      return {14'h0000, keyIrqOut, keyIrqOe};
   endfunction
   // cycles up to the next debounce tick
   task automatic gapTo();
      n = 0;
      do begin
         cyc(1);
         n++;
      end while (debounceTick !== 1'b1 && n < 2000);
   endtask
   // debounce ticks seen until the interrupt pin is pulled
   task automatic ticksToIrq();
      int k;
      t = 0;
      k = 0;
      do begin
         cyc(1);
         k++;
         if (debounceTick === 1'b1) t++;
      end while (keyIrqOe !== 1'b1 && k < 7000);
   endtask

   task automatic results();
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // hang guard
   initial begin
      #1500000;
      err_count++;
      results();
   end

   initial begin
      rst_n = 1'b0;
      fifoCount = 5'h00;
      ccPwmEn = 1'b0;
      autoSleepReq = 1'b0;
      keyPressEvt = 1'b0;
      portIntkCtl = 1'b1;
      err_count = 0;
      check_count = 0;
      repeat (12) @(posedge mclk);
      #2;
      rst_n = 1'b1;
      cyc(2);
      // reset state, readback and unmapped offset
      check(st(), 16'h0007);
      check({8'h00, columnGpoEn}, 16'h00FC);
      check(irq(), 16'h0000);
      rdc(8'h01, 8'h0A);
      rdc(8'h02, 8'hFF);
      rdc(8'h03, 8'h00);
      rdc(8'h05, 8'h00);
      // sleep, wake, release and timeout fields
      wr(8'h01, 8'h08);
      pulse(1'b1);
      check(st(), 16'h0005);
      wr(8'h01, 8'h0A);
      pulse(1'b1);
      check(st(), 16'h000F);
      rdc(8'h01, 8'h8A);
      pulse(1'b0);
      check(st(), 16'h0007);
      wr(8'h01, 8'h81);
      check(st(), 16'h0008);
      rdc(8'h01, 8'h81);
      wr(8'h01, 8'h00);
      check(st(), 16'h0001);
      // constant-current mode holds scanning
      ccPwmEn = 1'b1;
      cyc(2);
      check(st(), 16'h0009);
      wr(8'h01, 8'h08);
      pulse(1'b0);
      check(st(), 16'h000D);
      rdc(8'h01, 8'h88);
      ccPwmEn = 1'b0;
      cyc(2);
      check(st(), 16'h0005);
      // every column output code
      for (int k = 0; k < 8; k++) begin
         wr(8'h02, {k[2:0], 5'h1F});
         check({8'h00, columnGpoEn}, {8'h00, COLS[k]});
         rdc(8'h02, {k[2:0], 5'h1F});
      end
      // shortest and longest debounce period
      for (int f = 0; f < 32; f += 31) begin
         wr(8'h02, f[7:0]);
         repeat (3) gapTo();
         check(n[15:0], 16'((9 + f) * MSC));
      end
      // pin as general output, then as interrupt
      wr(8'h03, 8'h00);
      portIntkCtl = 1'b0;
      cyc(2);
      check(irq(), 16'h0001);
      wr(8'h03, 8'h20);
      check(irq(), 16'h0000);
      for (int k = 1; k < 8; k++) begin
         wr(8'h03, {k[2:0], 5'h00});
         fifoCount = 5'(2 * k + 1);
         cyc(3);
         check(irq(), 16'h0000);
         fifoCount = 5'(2 * k + 2);
         cyc(3);
         check(irq(), 16'h0001);
         fifoCount = 5'h00;
         cyc(3);
         check(irq(), 16'h0000);
      end
      wr(8'h03, 8'h22);
      fifoCount = 5'h04;
      cyc(3);
      check(irq(), 16'h0001);
      // periodic trigger, cleared by queue reads
      wr(8'h02, 8'h00);
      wr(8'h01, 8'h28);
      fifoCount = 5'h01;
      for (int i = 0; i < 2; i++) begin
         wr(8'h03, i ? 8'hFF : 8'hE1);
         // start right after a tick so no trigger races the clear
         gapTo();
         repeat (2) begin
            // one queue read drops the request
            rd(8'h00);
            check(irq(), 16'h0000);
            ticksToIrq();
         end
         check(t[15:0], i ? 16'h001F : 16'h0001);
      end
      results();
   end
endmodule
